// [rtl/lpd_pkg.sv]
package lpd_pkg;
// Overview of operation
// - dimming period lasts (N+1) x 1.5 us, N being a 13-bit count
// - period count may be rewritten over the serial interface at any time
// - each channel has a 16-bit on-time in 0.15 us steps
// - an enabled channel is never lit for less than 1 us
// - without grouping each of the ten channels starts in its own slot
// - enable bits at 0x00-0x01, on-time settings at 0x10-0x23
// - enabled channel turns on at its slot start for its on-time, but for at least 1 us
// - lit intervals may run past later slot starts and overlap
// - grouping bits at 0x08-0x09 join a channel to its lower neighbour
// - grouped channel uses neighbour's slot and on-time; own slot unused
// - larger groups all follow the lowest member's slot and on-time
// - slots recur in fixed order each period; vacated slots are kept
// - per-channel current code 1 to 64 mA, independent of grouping
// - disabling a group's first channel turns the whole group off
// - disabling another member leaves the rest on first channel's on-time
// - channels switch on or off dynamically; slots recomputed from settings

    // channel count and field widths
    localparam int         NUM_CH       = 10;
    localparam int         PERIOD_W     = 13;
    localparam int         ONTIME_W     = 16;
    localparam int         CUR_W        = 6;

    // register offsets
    localparam logic [7:0] ADDR_EN_LO   = 8'h00;
    localparam logic [7:0] ADDR_EN_HI   = 8'h01;
    localparam logic [7:0] ADDR_PER_LO  = 8'h02;
    localparam logic [7:0] ADDR_PER_HI  = 8'h03;
    localparam logic [7:0] ADDR_JOIN_LO = 8'h08;
    localparam logic [7:0] ADDR_JOIN_HI = 8'h09;
    localparam logic [7:0] ADDR_STAT_LO = 8'h0A;
    localparam logic [7:0] ADDR_STAT_HI = 8'h0B;
    localparam logic [7:0] ADDR_ON_BASE = 8'h10;
    localparam logic [7:0] ADDR_CUR_BASE = 8'h30;

    // reset values
    localparam logic [PERIOD_W-1:0] PERIOD_RST = 13'h0009; // short first period, settings land quickly
    localparam logic [7:0]          DEV_ADDR_RST = 8'h2A;

    // timing, in ns, and derived cycle counts
    localparam int CLK_NS          = 10;
    localparam int PERIOD_STEP_NS  = 1500;
    localparam int ONTIME_STEP_NS  = 150;
    localparam int MIN_ON_NS       = 1000;
    localparam int PERIOD_STEP_CYC = PERIOD_STEP_NS / CLK_NS;
    localparam int SLOT_UNIT_CYC   = PERIOD_STEP_CYC / NUM_CH;
    localparam int ONTIME_STEP_CYC = ONTIME_STEP_NS / CLK_NS;
    localparam int MIN_ON_CYC      = (MIN_ON_NS + CLK_NS - 1) / CLK_NS;

    // serial slave states
    typedef enum logic [3:0] {
        I2C_IDLE  = 4'h0,
        I2C_ADDR  = 4'h1,
        I2C_ACKA  = 4'h2,
        I2C_REG   = 4'h3,
        I2C_ACKR  = 4'h4,
        I2C_WDATA = 4'h5,
        I2C_ACKW  = 4'h6,
        I2C_RDATA = 4'h7,
        I2C_RACK  = 4'h8
    } lpd_i2c_state_t;
endpackage : lpd_pkg

// [rtl/lpd_slot_timer.sv]
`timescale 1ns/1ps
module lpd_slot_timer
    import lpd_pkg::*;
(
    // clock and reset
    input  wire logic                clock,
    input  wire logic                resetn,
    // programmed period count
    input  wire logic [PERIOD_W-1:0] periodCount,
    // slot timing
    output logic                     slotStart,
    output logic [3:0]               slotIdx,
    output logic                     periodLast
);
    logic [PERIOD_W-1:0] activeN_reg;
    logic [16:0]         slotCyc_reg;
    logic [3:0]          slotIdx_reg;
    logic [16:0]         slotLen;
    logic                slotEnd;

    // slot length is one tenth of the period: (N+1) x 15 cycles
    assign slotLen    = 17'((17'(activeN_reg) + 17'h1) * 17'(SLOT_UNIT_CYC));
    assign slotEnd    = (slotCyc_reg == slotLen - 17'h1);
    assign periodLast = slotEnd && (slotIdx_reg == 4'(NUM_CH - 1));
    assign slotStart  = (slotCyc_reg == 17'h0);
    assign slotIdx    = slotIdx_reg;

    // period count is taken only at the boundary
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            activeN_reg <= PERIOD_RST;
        end else if (periodLast) begin
            activeN_reg <= periodCount;
        end
    end

    // slot counters, sequential and periodic
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            slotCyc_reg <= '0;
            slotIdx_reg <= '0;
        end else if (slotEnd) begin
            slotCyc_reg <= '0;
            slotIdx_reg <= periodLast ? 4'h0 : slotIdx_reg + 4'h1;
        end else begin
            slotCyc_reg <= slotCyc_reg + 17'h1;
        end
    end

    a_slot_sequence: assert property (@(posedge clock) disable iff (!resetn)
        slotEnd |=> slotStart && (slotIdx == ($past(periodLast) ? 4'h0 : $past(slotIdx) + 4'h1)))
        else $error("slot index did not advance in order");
endmodule : lpd_slot_timer

// [rtl/lpd_sink_pwm.sv]
`timescale 1ns/1ps
module lpd_sink_pwm
    import lpd_pkg::*;
(
    // clock and reset
    input  wire logic                clock,
    input  wire logic                resetn,
    // slot trigger and settings
    input  wire logic                fire,
    input  wire logic                enable,
    input  wire logic [ONTIME_W-1:0] onTime,
    // sink drive
    output logic                     sinkOn
);
    logic [19:0] cnt_reg;
    logic [19:0] onLen;
    logic [19:0] load;
    logic        sinkOn_reg;
    logic [19:0] width_reg;

    // on-time in cycles, clamped to the minimum pulse
    always_comb begin
        onLen = 20'(20'(onTime) * 20'(ONTIME_STEP_CYC));
        load  = (onLen < 20'(MIN_ON_CYC)) ? 20'(MIN_ON_CYC) : onLen;
    end

    // remaining-cycle counter and output flop, retriggerable at each slot
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cnt_reg    <= '0;
            sinkOn_reg <= 1'b0;
        end else if (fire) begin
            cnt_reg    <= enable ? load : 20'h0;
            sinkOn_reg <= enable;
        end else begin
            cnt_reg    <= (cnt_reg != 20'h0) ? cnt_reg - 20'h1 : 20'h0;
            sinkOn_reg <= (cnt_reg > 20'h1);
        end
    end
    assign sinkOn = sinkOn_reg;

    // helper: length of the current lit interval
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            width_reg <= '0;
        end else begin
            width_reg <= sinkOn_reg ? width_reg + 20'h1 : 20'h0;
        end
    end

    a_min_width: assert property (@(posedge clock) disable iff (!resetn)
        $fell(sinkOn) |-> (width_reg >= 20'(MIN_ON_CYC)))
        else $error("lit interval shorter than minimum");
endmodule : lpd_sink_pwm

// [rtl/lpd_dimming_top.sv]
`timescale 1ns/1ps
module lpd_dimming_top
    import lpd_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = DEV_ADDR_RST[6:0]
) (
    // clock and reset
    input  wire logic                    clock,
    input  wire logic                    resetn,
    // serial register interface
    input  wire logic                    scl,
    input  wire logic                    sdaIn,
    output logic                         sdaOut,
    output logic                         sdaOeN,
    // sink channel drive
    output logic [NUM_CH-1:0]            sinkChannelOn,
    output logic [NUM_CH*CUR_W-1:0]      sinkChannelCurrent
);
    // serial slave state
    lpd_i2c_state_t      state_reg;
    logic                sclPrev_reg;
    logic                sdaPrev_reg;
    logic [7:0]          shift_reg;
    logic [3:0]          bitCnt_reg;
    logic [7:0]          ptr_reg;
    logic                sdaLow_reg;
    logic                nack_reg;
    logic                wrPulse_reg;
    logic [7:0]          wrAddr_reg;
    logic [7:0]          wrData_reg;
    logic                sclRise;
    logic                sclFall;
    logic                startCond;
    logic                stopCond;
    logic [7:0]          rdData;

    // software registers
    logic [NUM_CH-1:0]   en_reg;
    logic [NUM_CH-1:0]   join_reg;
    logic [PERIOD_W-1:0] period_reg;
    logic [ONTIME_W-1:0] onTime_reg [NUM_CH];
    logic [CUR_W-1:0]    cur_reg [NUM_CH];

    // settings in force for the running period
    logic [NUM_CH-1:0]   actEn_reg;
    logic [NUM_CH-1:0]   actJoin_reg;
    logic [ONTIME_W-1:0] actOnTime_reg [NUM_CH];

    // slot timing and group resolution
    logic                slotStart;
    logic [3:0]          slotIdx;
    logic                periodLast;
    logic [3:0]          leader [NUM_CH];
    logic [NUM_CH-1:0]   effEn;
    logic [NUM_CH-1:0]   fire;

    // bus line edges and conditions
    assign sclRise   = scl && !sclPrev_reg;
    assign sclFall   = !scl && sclPrev_reg;
    assign startCond = scl && sclPrev_reg && sdaPrev_reg && !sdaIn;
    assign stopCond  = scl && sclPrev_reg && !sdaPrev_reg && sdaIn;
    assign sdaOut    = 1'b0;
    assign sdaOeN    = !sdaLow_reg;

    // previous line samples
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sclPrev_reg <= 1'b1;
            sdaPrev_reg <= 1'b1;
        end else begin
            sclPrev_reg <= scl;
            sdaPrev_reg <= sdaIn;
        end
    end

    // serial slave: address, register pointer, write and read bytes
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_reg   <= I2C_IDLE;
            shift_reg   <= '0;
            bitCnt_reg  <= '0;
            ptr_reg     <= '0;
            sdaLow_reg  <= 1'b0;
            nack_reg    <= 1'b0;
            wrPulse_reg <= 1'b0;
            wrAddr_reg  <= '0;
            wrData_reg  <= '0;
        end else begin
            wrPulse_reg <= 1'b0;
            if (startCond) begin
                state_reg  <= I2C_ADDR;
                bitCnt_reg <= '0;
                sdaLow_reg <= 1'b0;
            end else if (stopCond) begin
                state_reg  <= I2C_IDLE;
                sdaLow_reg <= 1'b0;
            end else if (sclRise) begin
                if (state_reg == I2C_RACK) begin
                    nack_reg <= sdaIn;
                end else if (state_reg == I2C_ADDR || state_reg == I2C_REG ||
                             state_reg == I2C_WDATA || state_reg == I2C_RDATA) begin // ack slots keep r/w bit and count
                    shift_reg  <= {shift_reg[6:0], sdaIn};
                    bitCnt_reg <= bitCnt_reg + 4'h1;
                end
            end else if (sclFall) begin
                case (state_reg)
                    I2C_ADDR: begin
                        if (bitCnt_reg == 4'h8) begin
                            bitCnt_reg <= '0;
                            if (shift_reg[7:1] == DEV_ADDR) begin
                                sdaLow_reg <= 1'b1;
                                state_reg  <= I2C_ACKA;
                            end else begin
                                state_reg  <= I2C_IDLE;
                            end
                        end
                    end
                    I2C_ACKA: begin
                        if (shift_reg[0]) begin
                            shift_reg  <= rdData;
                            sdaLow_reg <= !rdData[7];
                            state_reg  <= I2C_RDATA;
                        end else begin
                            sdaLow_reg <= 1'b0;
                            state_reg  <= I2C_REG;
                        end
                    end
                    I2C_REG: begin
                        if (bitCnt_reg == 4'h8) begin
                            bitCnt_reg <= '0;
                            ptr_reg    <= shift_reg;
                            sdaLow_reg <= 1'b1;
                            state_reg  <= I2C_ACKR;
                        end
                    end
                    I2C_ACKR: begin
                        sdaLow_reg <= 1'b0;
                        state_reg  <= I2C_WDATA;
                    end
                    I2C_WDATA: begin
                        if (bitCnt_reg == 4'h8) begin
                            bitCnt_reg  <= '0;
                            wrPulse_reg <= 1'b1;
                            wrAddr_reg  <= ptr_reg;
                            wrData_reg  <= shift_reg;
                            sdaLow_reg  <= 1'b1;
                            state_reg   <= I2C_ACKW;
                        end
                    end
                    I2C_ACKW: begin
                        ptr_reg    <= ptr_reg + 8'h01;
                        sdaLow_reg <= 1'b0;
                        state_reg  <= I2C_WDATA;
                    end
                    I2C_RDATA: begin
                        if (bitCnt_reg == 4'h8) begin
                            bitCnt_reg <= '0;
                            ptr_reg    <= ptr_reg + 8'h01;
                            sdaLow_reg <= 1'b0;
                            state_reg  <= I2C_RACK;
                        end else begin
                            sdaLow_reg <= !shift_reg[7];
                        end
                    end
                    I2C_RACK: begin
                        if (nack_reg) begin
                            state_reg  <= I2C_IDLE;
                        end else begin
                            shift_reg  <= rdData;
                            sdaLow_reg <= !rdData[7];
                            state_reg  <= I2C_RDATA;
                        end
                    end
                    default: begin
                        sdaLow_reg <= 1'b0;
                    end
                endcase
            end
        end
    end

    // register writes
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            en_reg     <= '0;
            join_reg   <= '0;
            period_reg <= PERIOD_RST;
            for (int k = 0; k < NUM_CH; k++) begin
                onTime_reg[k] <= '0;
                cur_reg[k]    <= '0;
            end
        end else if (wrPulse_reg) begin
            case (wrAddr_reg)
                ADDR_EN_LO:   en_reg[7:0]           <= wrData_reg;
                ADDR_EN_HI:   en_reg[NUM_CH-1:8]    <= wrData_reg[NUM_CH-9:0];
                ADDR_JOIN_LO: join_reg[7:0]         <= wrData_reg;
                ADDR_JOIN_HI: join_reg[NUM_CH-1:8]  <= wrData_reg[NUM_CH-9:0];
                ADDR_PER_LO:  period_reg[7:0]       <= wrData_reg;
                ADDR_PER_HI:  period_reg[PERIOD_W-1:8] <= wrData_reg[PERIOD_W-9:0];
                default: begin
                end
            endcase
            for (int k = 0; k < NUM_CH; k++) begin
                if (wrAddr_reg == 8'(ADDR_ON_BASE + 8'(2 * k))) begin
                    onTime_reg[k][7:0] <= wrData_reg;
                end
                if (wrAddr_reg == 8'(ADDR_ON_BASE + 8'(2 * k + 1))) begin
                    onTime_reg[k][15:8] <= wrData_reg;
                end
                if (wrAddr_reg == 8'(ADDR_CUR_BASE + 8'(k))) begin
                    cur_reg[k] <= wrData_reg[CUR_W-1:0];
                end
            end
        end
    end

    // register reads; unmapped offsets and unused bits read as zero
    always_comb begin
        rdData = 8'h00;
        case (ptr_reg)
            ADDR_EN_LO:   rdData = en_reg[7:0];
            ADDR_EN_HI:   rdData = 8'(en_reg[NUM_CH-1:8]);
            ADDR_JOIN_LO: rdData = join_reg[7:0];
            ADDR_JOIN_HI: rdData = 8'(join_reg[NUM_CH-1:8]);
            ADDR_PER_LO:  rdData = period_reg[7:0];
            ADDR_PER_HI:  rdData = 8'(period_reg[PERIOD_W-1:8]);
            ADDR_STAT_LO: rdData = sinkChannelOn[7:0];
            ADDR_STAT_HI: rdData = 8'(sinkChannelOn[NUM_CH-1:8]);
            default: begin
                for (int k = 0; k < NUM_CH; k++) begin
                    if (ptr_reg == 8'(ADDR_ON_BASE + 8'(2 * k))) begin
                        rdData = onTime_reg[k][7:0];
                    end
                    if (ptr_reg == 8'(ADDR_ON_BASE + 8'(2 * k + 1))) begin
                        rdData = onTime_reg[k][15:8];
                    end
                    if (ptr_reg == 8'(ADDR_CUR_BASE + 8'(k))) begin
                        rdData = 8'(cur_reg[k]);
                    end
                end
            end
        endcase
    end

    // settings move into force only at the period boundary
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            actEn_reg   <= '0;
            actJoin_reg <= '0;
            for (int k = 0; k < NUM_CH; k++) begin
                actOnTime_reg[k] <= '0;
            end
        end else if (periodLast) begin
            actEn_reg   <= en_reg;
            actJoin_reg <= join_reg;
            for (int k = 0; k < NUM_CH; k++) begin
                actOnTime_reg[k] <= onTime_reg[k];
            end
        end
    end

    // group leader: a joined channel follows its lower neighbour's leader
    always_comb begin
        leader[0] = 4'h0;
        for (int k = 1; k < NUM_CH; k++) begin
            leader[k] = actJoin_reg[k] ? leader[k-1] : 4'(k);
        end
    end

    // slot and period timing
    lpd_slot_timer u_timer (
        .clock       (clock),
        .resetn      (resetn),
        .periodCount (period_reg),
        .slotStart   (slotStart),
        .slotIdx     (slotIdx),
        .periodLast  (periodLast)
    );

    // one pulse generator per channel, each free to overlap the others
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        assign effEn[g] = actEn_reg[leader[g]] && actEn_reg[g];
        assign fire[g]  = slotStart && (slotIdx == leader[g]);
        lpd_sink_pwm u_pwm (
            .clock  (clock),
            .resetn (resetn),
            .fire   (fire[g]),
            .enable (effEn[g]),
            .onTime (actOnTime_reg[leader[g]]),
            .sinkOn (sinkChannelOn[g])
        );
        assign sinkChannelCurrent[g*CUR_W +: CUR_W] = cur_reg[g];
    end

    a_group_start: assert property (@(posedge clock) disable iff (!resetn)
        $rose(sinkChannelOn[1]) && actJoin_reg[1] |-> $past(slotIdx) == 4'h0)
        else $error("joined channel started outside leader slot");
    a_lead_off: assert property (@(posedge clock) disable iff (!resetn)
        $rose(sinkChannelOn[2]) |-> $past(actEn_reg[leader[2]]))
        else $error("channel lit while its group leader is disabled");
    a_own_slot: assert property (@(posedge clock) disable iff (!resetn)
        $rose(sinkChannelOn[4]) && !actJoin_reg[4] |-> $past(slotIdx) == 4'h4)
        else $error("ungrouped channel started outside its slot");
    a_ack_addr: assert property (@(posedge clock) disable iff (!resetn)
        state_reg == I2C_ADDR && sclFall && bitCnt_reg == 4'h8 && shift_reg[7:1] == DEV_ADDR
        |=> !sdaOeN && state_reg == I2C_ACKA)
        else $error("matching address not acknowledged");
    a_write_apply: assert property (@(posedge clock) disable iff (!resetn)
        wrPulse_reg && wrAddr_reg == ADDR_EN_LO |=> en_reg[7:0] == $past(wrData_reg))
        else $error("enable write not stored");
    a_hold_active: assert property (@(posedge clock) disable iff (!resetn)
        !periodLast |=> $stable(actEn_reg) && $stable(actJoin_reg))
        else $error("settings changed inside a period");
    a_group_match: assert property (@(posedge clock) disable iff (!resetn)
        actJoin_reg[4] && actJoin_reg[3] && effEn[4] |-> sinkChannelOn[4] == sinkChannelOn[2])
        else $error("group members not switching together");
endmodule : lpd_dimming_top

// [sim/lpd_led_model.sv]
`timescale 1ns/1ps
module lpd_led_model
    import lpd_pkg::*;
(
    // clock and reset
    input  wire logic                    clock,
    input  wire logic                    resetn,
    // device drive
    input  wire logic [NUM_CH-1:0]       sinkChannelOn,
    input  wire logic [NUM_CH*CUR_W-1:0] sinkChannelCurrent,
    // what the strings saw
    output int                           riseAt [NUM_CH],
    output int                           litLen [NUM_CH],
    output int                           currentMa [NUM_CH]
);
    int                cyc;
    int                run [NUM_CH];
    logic [NUM_CH-1:0] onReg;

    // string current in mA, one step per code
    always_comb
        for (int k = 0; k < NUM_CH; k++)
            currentMa[k] = int'(sinkChannelCurrent[k*CUR_W+:CUR_W]) + 1;

    // light-up moment and lit length per string
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cyc    <= 0;
            onReg  <= '0;
            run    <= '{default: 0};
            riseAt <= '{default: 0};
            litLen <= '{default: 0};
        end else begin
            cyc   <= cyc + 1;
            onReg <= sinkChannelOn;
            for (int k = 0; k < NUM_CH; k++) begin
                if (sinkChannelOn[k]) run[k] <= onReg[k] ? run[k] + 1 : 1;
                if (sinkChannelOn[k] && !onReg[k]) riseAt[k] <= cyc;
                if (!sinkChannelOn[k] && onReg[k]) litLen[k] <= run[k];
            end
        end
    end
endmodule : lpd_led_model

// [sim/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    import lpd_pkg::*;
    localparam int         NP    = 3;
    localparam int         PER   = (NP + 1) * PERIOD_STEP_CYC;
    localparam int         SLOT  = PER / NUM_CH;
    localparam int         LIMIT = (int'(PERIOD_RST) + 1) * PERIOD_STEP_CYC + 90000;
    localparam logic [7:0] WA    = {DEV_ADDR_RST[6:0], 1'b0};
    logic                    clock, resetn, scl, sdaM, sdaOut, sdaOeN;
    logic [NUM_CH-1:0]       sinkChannelOn, seen;
    logic [NUM_CH*CUR_W-1:0] sinkChannelCurrent;
    logic [7:0]              q;
    int                      riseAt [NUM_CH], litLen [NUM_CH], currentMa [NUM_CH];
    int                      n_errors, n_tests, cyc;
    wire                     sdaLine = sdaM & (sdaOeN | sdaOut);

    // device and the strings it drives
    lpd_dimming_top dut (.clock(clock), .resetn(resetn), .scl(scl), .sdaIn(sdaLine), .sdaOut(sdaOut),
        .sdaOeN(sdaOeN), .sinkChannelOn(sinkChannelOn), .sinkChannelCurrent(sinkChannelCurrent));
    lpd_led_model leds (.clock(clock), .resetn(resetn), .sinkChannelOn(sinkChannelOn),
        .sinkChannelCurrent(sinkChannelCurrent), .riseAt(riseAt), .litLen(litLen), .currentMa(currentMa));

    // clock and hang limit
    initial begin
        clock = 0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc == LIMIT) begin
            n_errors++;
            print_verdict();
        end
    end

    // wait edges, then step off them
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick
    task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %0h seen %0h", w, e, g);
        end
    endtask : chk
    // start when s1 low, stop when high
    task automatic cond(input logic s0, input logic s1);
        tick(1);
        sdaM = s0;
        tick(3);
        scl = 1;
        tick(4);
        sdaM = s1;
        tick(4);
        if (!s1) scl = 0;
    endtask : cond
    // eight bits plus acknowledge slot
    task automatic xfer(input logic [7:0] d, input logic b9, output logic [7:0] r, output logic a);
        logic [8:0] w;
        logic [8:0] g;
        w = {d, b9};
        for (int i = 8; i >= 0; i--) begin
            tick(1);
            sdaM = w[i];
            tick(3);
            scl = 1;
            tick(2);
            g[i] = sdaLine;
            tick(2);
            scl = 0;
        end
        r = g[8:1];
        a = g[0];
    endtask : xfer
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        logic [2:0] a;
        cond(1, 0);
        xfer(WA, 1, q, a[0]);
        xfer(p, 1, q, a[1]);
        xfer(d, 1, q, a[2]);
        cond(0, 1);
        chk("write ack", 0, a);
    endtask : wr
    task automatic rd(input logic [7:0] p, input logic [7:0] e);
        logic [3:0] a;
        logic [7:0] r;
        cond(1, 0);
        xfer(WA, 1, r, a[0]);
        xfer(p, 1, r, a[1]);
        cond(1, 0);
        xfer(WA | 8'h01, 1, r, a[2]);
        xfer(8'hFF, 1, r, a[3]);
        cond(0, 1);
        chk("read ack", 0, a[2:0]);
        chk("read data", e, r);
    endtask : rd
    // slot and width of each channel from its leader
    task automatic chk_lead(input int ld [NUM_CH]);
        for (int k = 0; k < NUM_CH; k++) begin
            chk("slot offset", ld[k] * SLOT, ((riseAt[k] - riseAt[0]) % PER + PER) % PER);
            chk("lit width", (9 + ld[k]) * ONTIME_STEP_CYC, litLen[k]);
        end
    endtask : chk_lead
    task automatic scan(input logic [NUM_CH-1:0] e);
        seen = '0;
        repeat (PER) begin
            tick(1);
            seen |= sinkChannelOn;
        end
        chk("lit channels", e, seen);
    endtask : scan

    // scenarios
    task automatic t_period();
        int p;
        wr(ADDR_PER_LO, 8'(NP));
        wr(ADDR_PER_HI, 8'h00);
        wr(ADDR_ON_BASE, 8'd10);
        wr(ADDR_EN_LO, 8'h01);
        while (sinkChannelOn[0] !== 1'b1) tick(1);
        tick(3 * PER);
        p = riseAt[0];
        tick(PER);
        chk("period", PER, riseAt[0] - p);
        chk("width", 10 * ONTIME_STEP_CYC, litLen[0]);
        wr(ADDR_ON_BASE, 8'd1);
        tick(3 * PER);
        chk("short width", MIN_ON_CYC, litLen[0]);
        $display("test period done");
    endtask : t_period
    task automatic t_slots();
        for (int k = 0; k < NUM_CH; k++) wr(8'(ADDR_ON_BASE + 2 * k), 8'(9 + k));
        wr(ADDR_EN_LO, 8'hFF);
        wr(ADDR_EN_HI, 8'h03);
        tick(3 * PER);
        chk_lead('{0, 1, 2, 3, 4, 5, 6, 7, 8, 9});
        wr(ADDR_JOIN_LO, 8'h1A);
        wr(ADDR_JOIN_HI, 8'h02);
        tick(3 * PER);
        chk_lead('{0, 0, 2, 2, 2, 5, 6, 7, 8, 8});
        $display("test slots done");
    endtask : t_slots
    task automatic t_disable();
        wr(ADDR_EN_LO, 8'hF7);
        tick(2 * PER);
        scan(10'h3F7);
        chk("member width", 11 * ONTIME_STEP_CYC, litLen[4]);
        wr(ADDR_EN_LO, 8'hFB);
        tick(2 * PER);
        scan(10'h3E3);
        $display("test disable done");
    endtask : t_disable
    task automatic t_regs();
        rd(ADDR_EN_LO, 8'hFB);
        rd(ADDR_EN_HI, 8'h03);
        rd(ADDR_JOIN_LO, 8'h1A);
        rd(8'(ADDR_ON_BASE + 4), 8'h0B);
        rd(8'h40, 8'h00);
        rd(ADDR_PER_LO, 8'(NP));
        wr(ADDR_CUR_BASE, 8'h3F);
        wr(8'(ADDR_CUR_BASE + 1), 8'h05);
        tick(4);
        chk("current code", 6'h3F, sinkChannelCurrent[5:0]);
        chk("top current", 64, currentMa[0]);
        chk("grouped current", 6, currentMa[1]);
        cond(1, 0);
        xfer(WA ^ 8'h02, 1, q, seen[0]);
        cond(0, 1);
        chk("foreign ack", 1, seen[0]);
        $display("test registers done");
    endtask : t_regs

    // closing report
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    // reset, then the scenarios in order
    initial begin
        resetn = 0;
        scl = 1;
        sdaM = 1;
        tick(20);
        resetn = 1;
        tick(2);
        t_period();
        t_slots();
        t_disable();
        t_regs();
        print_verdict();
    end
endmodule : tb_top
